// ### logic/emb_pkg.sv
// constants and types of the sixteen-bit external memory bus
package emb_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int BYTE_W = 8;

	// write_mode_select encodings of memory_interface_control
	localparam logic [1:0] WM_BYTE_WRITE  = 2'h0;
	localparam logic [1:0] WM_BYTE_SELECT = 2'h1;
	localparam logic [1:0] WM_WORD_WRITE  = 2'h2;

	localparam int CLK_PERIOD_NS = 4;
	// least width of the read or write strobe phase
	localparam int DATA_TIME_NS  = 12;
	localparam int DATA_CYCLES_I = (DATA_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W         = 2;
	localparam logic [CNT_W-1:0] DATA_LAST = CNT_W'(DATA_CYCLES_I - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO  = CNT_W'(0);

	localparam int SYNC_STAGES = 2;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ADDR = 4'h2,
		ST_DATA = 4'h4,
		ST_END  = 4'h8
	} emb_state_e;

	typedef struct packed {
		emb_state_e          st;
		logic [CNT_W-1:0]    cnt;
		logic                is_wr;
		logic                strobe_hi;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   wdata;
		logic [BYTE_W-1:0]   hold_byte;
		logic                ext_en;
		logic                cfg_taken;
		logic                ale;
		logic                oe_n;
		logic                ce_n;
		logic                wrh_n;
		logic                wrl_n;
		logic                ub_n;
		logic                lb_n;
		logic                ba0;
		logic [DATA_W-1:0]   ad_out;
		logic                ad_oe;
		logic [DATA_W-1:0]   rd_data;
		logic                rd_done;
		logic                wr_done;
		logic                ready;
	} emb_regs_s;

endpackage

// ### logic/emb_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module emb_sync
	import emb_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	// first stage feeds only the second stage
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule
`default_nettype wire

// ### logic/emb_bus.sv
// sixteen-bit multiplexed external memory bus engine
`timescale 1ns/1ps
`default_nettype none
module emb_bus
	import emb_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic              cfg_bus16_en,
	input  wire logic              sleep_req,
	input  wire logic [1:0]        write_mode_select,
	input  wire logic              rd_req,
	input  wire logic [ADDR_W-1:0] rd_addr,
	input  wire logic              table_write_instruction,
	input  wire logic [ADDR_W-1:0] table_pointer,
	input  wire logic [BYTE_W-1:0] table_latch_data,
	input  wire logic [DATA_W-1:0] muxed_addr_data_bus_in,
	output logic [DATA_W-1:0]      muxed_addr_data_bus_out,
	output logic                   muxed_addr_data_bus_oe,
	output logic                   addr_latch_strobe,
	output logic                   read_strobe_n,
	output logic                   chip_select_n,
	output logic                   write_strobe_high_n,
	output logic                   write_strobe_low_n,
	output logic                   upper_byte_select_n,
	output logic                   lower_byte_select_n,
	output logic                   byte_address_bit,
	output logic [DATA_W-1:0]      rd_data,
	output logic                   rd_done,
	output logic                   wr_done,
	output logic                   req_ready
);

	emb_regs_s         r_reg;
	emb_regs_s         r_next;
	logic [DATA_W-1:0] bus_in_sync;
	logic              strap_sync;

	// edges after reset release before the synchronised strap can be trusted
	localparam logic [CNT_W-1:0] STRAP_WAIT = CNT_W'(SYNC_STAGES);

	emb_sync #(.WIDTH(DATA_W)) u_sync_bus (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.async_in (muxed_addr_data_bus_in),
		.sync_out (bus_in_sync)
	);

	emb_sync #(.WIDTH(1)) u_sync_strap (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.async_in (cfg_bus16_en),
		.sync_out (strap_sync)
	);

	always_comb begin
		r_next         = r_reg;
		r_next.rd_done = 1'b0;
		r_next.wr_done = 1'b0;

		// the mode strap is taken once, only after it has crossed both sync
		// stages; taking it earlier would see the synchroniser's reset level
		// later pin changes are ignored so the mode cannot move at run time
		if (!r_reg.cfg_taken) begin
			if (r_reg.cnt == STRAP_WAIT) begin
				r_next.cfg_taken = 1'b1;
				r_next.ext_en    = strap_sync;
				r_next.cnt       = CNT_ZERO;
			end else begin
				r_next.cnt = r_reg.cnt + CNT_W'(1);
			end
		end

		case (r_reg.st)
			ST_IDLE: begin
				if (r_reg.ready && !sleep_req) begin
					if (rd_req) begin
						r_next.st    = ST_ADDR;
						r_next.is_wr = 1'b0;
						r_next.addr  = rd_addr;
					end else if (table_write_instruction) begin
						r_next.is_wr     = 1'b1;
						r_next.addr      = table_pointer;
						r_next.strobe_hi = table_pointer[0];
						r_next.wdata     = {table_latch_data, table_latch_data};
						if (write_mode_select == WM_BYTE_WRITE ||
						    write_mode_select == WM_BYTE_SELECT) begin
							r_next.st = ST_ADDR;
						end else if (!table_pointer[0]) begin
							// word write: even byte waits for its odd partner
							r_next.hold_byte = table_latch_data;
							r_next.wr_done   = 1'b1;
						end else begin
							r_next.st        = ST_ADDR;
							r_next.strobe_hi = 1'b1;
							r_next.wdata     = {table_latch_data, r_reg.hold_byte};
						end
					end
				end
			end
			ST_ADDR: begin
				r_next.st  = ST_DATA;
				r_next.cnt = CNT_ZERO;
			end
			ST_DATA: begin
				if (r_reg.cnt == DATA_LAST) begin
					r_next.st = ST_END;
					if (!r_reg.is_wr) begin
						r_next.rd_data = bus_in_sync;
					end
				end else begin
					r_next.cnt = r_reg.cnt + CNT_W'(1);
				end
			end
			ST_END: begin
				r_next.st      = ST_IDLE;
				r_next.rd_done = !r_reg.is_wr;
				r_next.wr_done = r_reg.is_wr;
			end
			default: begin
				r_next.st = ST_IDLE;
			end
		endcase

		// sleep abandons an access without a done pulse
		if (sleep_req) begin
			r_next.st      = ST_IDLE;
			r_next.rd_done = 1'b0;
			r_next.wr_done = 1'b0;
		end

		// pin levels follow the state being entered so they leave flops cleanly
		r_next.ale    = (r_next.st == ST_ADDR);
		r_next.ce_n   = (r_next.st == ST_IDLE) || sleep_req;
		r_next.oe_n   = !(r_next.st == ST_DATA && !r_next.is_wr);
		r_next.wrh_n  = 1'b1;
		r_next.wrl_n  = 1'b1;
		r_next.ub_n   = 1'b1;
		r_next.lb_n   = 1'b1;
		r_next.ba0    = 1'b0;
		r_next.ad_oe  = 1'b0;
		r_next.ad_out = r_reg.ad_out;
		r_next.ready  = (r_next.st == ST_IDLE) && r_next.ext_en && !sleep_req;

		case (r_next.st)
			ST_ADDR: begin
				r_next.ad_oe  = 1'b1;
				r_next.ad_out = r_next.addr;
			end
			ST_DATA: begin
				// reads release the bus; writes redrive it with data
				r_next.ad_oe  = r_next.is_wr;
				r_next.ad_out = r_next.wdata;
				if (!r_next.is_wr) begin
					r_next.ub_n = 1'b0;
					r_next.lb_n = 1'b0;
				end else if (write_mode_select == WM_BYTE_SELECT) begin
					r_next.wrh_n = 1'b0;
					r_next.ba0   = r_next.addr[0];
					r_next.ub_n  = !r_next.addr[0];
					r_next.lb_n  = r_next.addr[0];
				end else if (write_mode_select == WM_BYTE_WRITE) begin
					r_next.wrh_n = !r_next.strobe_hi;
					r_next.wrl_n = r_next.strobe_hi;
				end else begin
					r_next.wrh_n = 1'b0;
				end
			end
			ST_END: begin
				// writes keep data one cycle past the strobe's rising edge
				r_next.ad_oe  = r_next.is_wr;
				r_next.ad_out = r_next.wdata;
				r_next.ba0    = r_reg.ba0;
			end
			default: begin
				r_next.ad_oe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			r_reg       <= '0;
			r_reg.st    <= ST_IDLE;
			r_reg.oe_n  <= 1'b1;
			r_reg.ce_n  <= 1'b1;
			r_reg.wrh_n <= 1'b1;
			r_reg.wrl_n <= 1'b1;
			r_reg.ub_n  <= 1'b1;
			r_reg.lb_n  <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign muxed_addr_data_bus_out = r_reg.ad_out;
	assign muxed_addr_data_bus_oe  = r_reg.ad_oe;
	assign addr_latch_strobe       = r_reg.ale;
	assign read_strobe_n           = r_reg.oe_n;
	assign chip_select_n           = r_reg.ce_n;
	assign write_strobe_high_n     = r_reg.wrh_n;
	assign write_strobe_low_n      = r_reg.wrl_n;
	assign upper_byte_select_n     = r_reg.ub_n;
	assign lower_byte_select_n     = r_reg.lb_n;
	assign byte_address_bit        = r_reg.ba0;
	assign rd_data                 = r_reg.rd_data;
	assign rd_done                 = r_reg.rd_done;
	assign wr_done                 = r_reg.wr_done;
	assign req_ready               = r_reg.ready;

endmodule
`default_nettype wire

// ### verif/emb_bus_sva.sv
// assertions on the pins of the external memory bus engine
`timescale 1ns/1ps
`default_nettype none
module emb_bus_sva
	import emb_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              rst_n,
	input wire logic              sleep_req,
	input wire logic [1:0]        write_mode_select,
	input wire logic [DATA_W-1:0] muxed_addr_data_bus_out,
	input wire logic              muxed_addr_data_bus_oe,
	input wire logic              addr_latch_strobe,
	input wire logic              read_strobe_n,
	input wire logic              chip_select_n,
	input wire logic              write_strobe_high_n,
	input wire logic              write_strobe_low_n,
	input wire logic              upper_byte_select_n,
	input wire logic              lower_byte_select_n,
	input wire logic              rd_done,
	input wire logic              wr_done
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic wr_any;
	logic bw;
	assign wr_any = !write_strobe_high_n || !write_strobe_low_n;
	assign bw     = wr_any && write_mode_select == WM_BYTE_WRITE;
	// a bus cycle left alone by sleep must finish five cycles after its address
	sequence s_addr;
		addr_latch_strobe && !sleep_req ##1 !sleep_req[*4];
	endsequence
	AST_ALE_BUS: assert property (
		addr_latch_strobe |-> !chip_select_n && muxed_addr_data_bus_oe)
		else $error("latch strobe without driven bus");
	AST_ALE_ONE: assert property (
		addr_latch_strobe |=> !addr_latch_strobe) else $error("latch strobe too long");
	AST_RD_OPEN: assert property (
		$fell(read_strobe_n) |-> $past(addr_latch_strobe) && !upper_byte_select_n
		&& !lower_byte_select_n) else $error("read strobe not after address");
	AST_RD_BUS: assert property (
		!read_strobe_n |-> !muxed_addr_data_bus_oe && !chip_select_n)
		else $error("read with bus driven or chip idle");
	AST_WR_CS: assert property (
		wr_any |-> !chip_select_n && muxed_addr_data_bus_oe) else $error("write outside access");
	AST_SLEEP: assert property (
		sleep_req [*2] |-> chip_select_n) else $error("chip select during sleep");
	AST_BW_ONE: assert property (
		bw |-> write_strobe_high_n != write_strobe_low_n) else $error("byte strobes not one");
	AST_BW_DATA: assert property (
		bw |-> muxed_addr_data_bus_out[15:8] == muxed_addr_data_bus_out[7:0])
		else $error("byte write halves differ");
	AST_DONE: assert property (
		s_addr |=> rd_done || wr_done) else $error("access not finished");
endmodule
bind emb_bus emb_bus_sva u_sva (.ref_clk, .rst_n, .sleep_req, .write_mode_select,
	.muxed_addr_data_bus_out, .muxed_addr_data_bus_oe, .addr_latch_strobe, .read_strobe_n,
	.chip_select_n, .write_strobe_high_n, .write_strobe_low_n, .upper_byte_select_n,
	.lower_byte_select_n, .rd_done, .wr_done);
`default_nettype wire

// ### verif/emb_mem_model.sv
// behavioural external memory on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module emb_mem_model
	import emb_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic [DATA_W-1:0] bus_out,
	input  wire logic              ale,
	input  wire logic              oe_n,
	input  wire logic              wrh_n,
	input  wire logic              wrl_n,
	input  wire logic              ub_n,
	input  wire logic              lb_n,
	input  wire logic              ba0,
	output logic [DATA_W-1:0]      bus_in
);
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] last = '0;
	logic [DATA_W-1:0] rec_d = '0;
	logic [3:0]        rec_sel = '0;
	logic              rec_ba = 1'b0;
	// released bus toggles so a stale value never looks valid
	assign bus_in = oe_n ? ~last : addr ^ 16'ha5c3;
	always @(posedge ref_clk) begin
		last <= bus_in;
		if (ale)
			addr <= bus_out;
		if (!wrh_n || !wrl_n) begin
			rec_d <= bus_out;
			rec_sel <= {!wrh_n, !wrl_n, !ub_n, !lb_n};
			rec_ba <= ba0;
		end
	end
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// self-checking bench of the external memory bus engine
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import emb_pkg::*;
;
	logic ref_clk = 0, rst_n = 0, cfg = 1, sleep_req = 0, rd_req = 0, twi = 0;
	logic [1:0]  wms = WM_BYTE_WRITE;
	logic [15:0] addr = '0, bus_in, bus_out, rd_data;
	logic [7:0]  tl = '0;
	logic oe, ale, oe_n, cs_n, wrh_n, wrl_n, ub_n, lb_n, ba0, rd_done, wr_done, rdy;
	int bad_count = 0, n_tests = 0;
	emb_bus u_dut (.ref_clk, .rst_n, .cfg_bus16_en(cfg), .sleep_req, .write_mode_select(wms),
		.rd_req, .rd_addr(addr), .table_write_instruction(twi), .table_pointer(addr),
		.table_latch_data(tl), .muxed_addr_data_bus_in(bus_in),
		.muxed_addr_data_bus_out(bus_out), .muxed_addr_data_bus_oe(oe),
		.addr_latch_strobe(ale), .read_strobe_n(oe_n), .chip_select_n(cs_n),
		.write_strobe_high_n(wrh_n), .write_strobe_low_n(wrl_n), .upper_byte_select_n(ub_n),
		.lower_byte_select_n(lb_n), .byte_address_bit(ba0), .rd_data, .rd_done, .wr_done,
		.req_ready(rdy));
	emb_mem_model u_mem (.ref_clk, .bus_out, .ale, .oe_n, .wrh_n, .wrl_n, .ub_n, .lb_n, .ba0,
		.bus_in);
	initial forever #2 ref_clk = ~ref_clk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// request is a level, so it is dropped on the very edge that takes it
	task automatic access(input logic rd, input logic [15:0] a, input logic [7:0] d,
			output logic ok);
		int k;
		@(posedge ref_clk);
		rd_req <= rd;
		twi <= !rd;
		addr <= a;
		tl <= d;
		k = 0;
		do begin @(negedge ref_clk); k++; end while (rdy !== 1'b1 && k < 50);
		@(posedge ref_clk);
		rd_req <= 1'b0;
		twi <= 1'b0;
		k = 0;
		do begin @(negedge ref_clk); k++; end while (!rd_done && !wr_done && k < 12);
		ok = k < 12;
	endtask
	task automatic t_wr(input logic [1:0] m, input logic [15:0] p, input logic [7:0] d,
			input logic [3:0] sel, input logic [15:0] dat);
		logic ok;
		@(posedge ref_clk);
		wms <= m;
		access(1'b0, p, d, ok);
		chk(ok, 1);
		chk(u_mem.rec_sel, sel);
		if (m != WM_BYTE_SELECT) begin
			chk(u_mem.rec_d, dat);
			chk(u_mem.rec_ba, 16'h0000);
		end else begin
			chk(u_mem.rec_ba, p[0]);
		end
	endtask
	task automatic t_read;
		logic ok;
		access(1'b1, 16'h1234, 8'h00, ok);
		chk(ok, 1);
		chk(rd_data, 16'h1234 ^ 16'ha5c3);
		// a strap change after the mode is taken must not disable the bus
		@(posedge ref_clk);
		cfg <= 1'b0;
		access(1'b1, 16'hfffe, 8'h00, ok);
		chk(ok, 1);
		chk(rd_data, 16'hfffe ^ 16'ha5c3);
		$display("read test finished");
	endtask
	task automatic t_writes;
		logic ok;
		t_wr(WM_BYTE_WRITE, 16'h0010, 8'h5a, 4'b0100, 16'h5a5a);
		t_wr(WM_BYTE_WRITE, 16'h0011, 8'hc3, 4'b1000, 16'hc3c3);
		@(posedge ref_clk);
		wms <= WM_WORD_WRITE;
		access(1'b0, 16'h0020, 8'h11, ok);
		chk(ok, 1);
		t_wr(WM_WORD_WRITE, 16'h0021, 8'h22, 4'b1000, 16'h2211);
		t_wr(WM_BYTE_SELECT, 16'h0031, 8'h77, 4'b1010, 16'h0000);
		t_wr(WM_BYTE_SELECT, 16'h0030, 8'h66, 4'b1001, 16'h0000);
		$display("write test finished");
	endtask
	task automatic t_sleep;
		logic ok;
		@(posedge ref_clk);
		sleep_req <= 1'b1;
		access(1'b1, 16'h0042, 8'h00, ok);
		chk(ok, 0);
		chk(cs_n, 1);
		@(posedge ref_clk);
		sleep_req <= 1'b0;
		$display("sleep test finished");
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#10000;
		bad_count++;
		end_of_test();
	end
	initial begin
		repeat (2) @(posedge ref_clk);
		chk(cs_n, 1);
		rst_n <= 1'b1;
		t_read();
		t_writes();
		t_sleep();
		end_of_test();
	end
endmodule
`default_nettype wire
